// ===== dcac_cnt_if.sv
`timescale 1ns/100ps

// Bundle between the sequencer and the counter pair.
interface dcac_cnt_if;
   logic                      clear;
   logic                      step;
   logic                      high;
   logic [dcac_pkg::CNT_W-1:0] high_cnt;
   logic                      wrap;

   modport ctrl (output clear, output step, output high, input high_cnt, input wrap);
   modport cnt  (input clear, input step, input high, output high_cnt, output wrap);
endinterface

// ===== dcac_counters.sv
`timescale 1ns/100ps

// High-time and total counters; the total steps once per sample, the high-time counter only on high samples.
module dcac_counters
(
   input  wire logic sys_clk,
   input  wire logic rst_n,
   dcac_cnt_if.cnt   cif
);

   logic [dcac_pkg::CNT_W-1:0] high_r;
   logic [dcac_pkg::CNT_W-1:0] high_nxt;
   logic [dcac_pkg::CNT_W-1:0] total_r;
   logic [dcac_pkg::CNT_W-1:0] total_nxt;
   logic                       wrap_nxt;
   logic [dcac_pkg::CNT_W:0]   high_sum;
   logic [dcac_pkg::CNT_W:0]   total_sum;

   // Add one with carry out; used by both counters.
   function automatic logic [dcac_pkg::CNT_W:0] inc(input logic [dcac_pkg::CNT_W-1:0] v);
      inc = {1'b0, v} + 13'h0001;
   endfunction

   // Incremented values with carry; only the total counter uses its carry.
   assign high_sum  = inc(high_r);
   assign total_sum = inc(total_r);

   // Next counts; the total counter steps on every sample regardless of branch.
   always_comb
   begin
      high_nxt  = high_r;
      total_nxt = total_r;
      wrap_nxt  = 1'b0;
      if (cif.clear)
      begin
         high_nxt  = dcac_pkg::CNT_RESET;
         total_nxt = dcac_pkg::TOTAL_PRELOAD;
      end
      else if (cif.step)
      begin
         if (cif.high)
            high_nxt = high_sum[dcac_pkg::CNT_W-1:0];
         {wrap_nxt, total_nxt} = total_sum;
      end
   end

   // Counter registers.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         high_r  <= dcac_pkg::CNT_RESET;
         total_r <= dcac_pkg::CNT_RESET;
      end
      else
      begin
         high_r  <= high_nxt;
         total_r <= total_nxt;
      end
   end

   assign cif.high_cnt = high_r;
   assign cif.wrap     = wrap_nxt;

   a_high_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      cif.step && !cif.high && !cif.clear |=> high_r == $past(high_r))
      else $error("High counter moved on a low sample.");

endmodule

// ===== dcac_pkg.sv
package dcac_pkg;

   // ****************************************************************
   // Widths and counts.
   // ****************************************************************
   localparam int          CNT_W           = 12;
   localparam logic [12:0] TOTAL_SAMPLES   = 13'h0800;
   // Preload so the 12-bit total counter carries out after the sample count.
   localparam logic [11:0] TOTAL_PRELOAD   = 12'h0800;
   localparam logic [11:0] CNT_RESET       = 12'h0000;
   // Cycles between comparator samples; equal for both branches.
   localparam logic [3:0]  SAMPLE_PERIOD   = 4'h4;
   localparam logic [3:0]  DIV_RESET       = 4'h0;

endpackage

// ===== dcac_rc_model.sv
`timescale 1ns/100ps

// Comparator watching an RC network charged by the drive pin.
module dcac_rc_model
(
   input  wire logic sys_clk,
   input  wire logic drive_level,
   input  var  int   vin,
   output logic      comp
);
   int vc = 0;

   // Capacitor moves 1/64 of its gap toward the driven reference each cycle.
   always @(posedge sys_clk)
   begin
      if (drive_level === 1'b1)
         vc <= vc + ((65536 - vc) >>> 6);
      else
         vc <= vc - (vc >>> 6);
   end

   // High while the input sits above the capacitor voltage.
   assign comp = (vin > vc);
endmodule

// ===== dcac_tb_top.sv
`timescale 1ns/100ps

module duty_cycle_adc_counter_tb_top;
   logic        sys_clk;
   logic        nrst = 1'b0;
   logic        start = 1'b0;
   logic        invert_drive = 1'b0;
   logic        comparator_sense_input;
   logic        drive_out;
   logic        busy;
   logic        done;
   logic [11:0] result;
   int          vin = 0;
   int          miscompares = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          hi_cyc = 0;
   int          busy_cyc = 0;

   // ****************************************************************
   // Clock, design and partner.
   // ****************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   dcac_top i_dut (.sys_clk(sys_clk), .nrst(nrst), .start(start),
                   .invert_drive(invert_drive),
                   .comparator_sense_input(comparator_sense_input),
                   .drive_out(drive_out), .busy(busy), .done(done), .result(result));

   // An inverting buffer sits between the pin and the network when inverted.
   dcac_rc_model i_rc (.sys_clk(sys_clk), .drive_level(drive_out ^ invert_drive),
                       .vin(vin), .comp(comparator_sense_input));

   // ****************************************************************
   // Reference model and hang guard.
   // ****************************************************************
   // Counts window cycles and cycles spent driving the positive reference.
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (start === 1'b1 && busy === 1'b0)
      begin
         hi_cyc <= 0;
         busy_cyc <= 0;
      end
      else if (busy === 1'b1)
      begin
         busy_cyc <= busy_cyc + 1;
         hi_cyc <= hi_cyc + ((drive_out ^ invert_drive) === 1'b1);
      end
      if (cyc == 80000)
      begin
         miscompares++;
         finish_test();
      end
   end

   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      n_checks++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   function automatic logic near(input int a, input int b, input int tol);
      return (a - b <= tol) && (b - a <= tol);
   endfunction

   // One conversion, with a refused start in mid-window.
   task automatic convert(input int v, input logic inv);
      int n;
      n = 0;
      @(posedge sys_clk);
      vin <= v;
      invert_drive <= inv;
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      repeat (100) @(posedge sys_clk);
      start <= 1'b1;
      @(posedge sys_clk);
      start <= 1'b0;
      while (done !== 1'b1 && n < 9000)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      check("done", 1'b1, done);
      check("window", 1'b1, near(busy_cyc, 1 + 2048 * 4, 2));
      check("high_count", 1'b1, near(hi_cyc / 4, int'(result), 2));
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial
   begin
      int v;
      logic inv;
      v = $urandom(86959);
      invert_drive <= 1'b1;
      repeat (8) @(posedge sys_clk);
      check("rst_busy", 1'b0, busy);
      check("rst_done", 1'b0, done);
      check("rst_result", 12'h0000, result);
      check("rst_drive", 1'b1, drive_out);
      nrst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      $display("test reset ended");
      // Input at the low reference never drives high: result stays zero.
      repeat (2)
      begin
         convert(0, 1'b0);
         check("zero_result", 12'h0000, result);
      end
      $display("test zero_input ended");
      // Random inputs; the first pass only settles the capacitor.
      repeat (3)
      begin
         v = 16384 + $urandom_range(32768);
         inv = $urandom_range(1);
         convert(v, inv);
         convert(v, inv);
         check("ratio", 1'b1, near(int'(result), v >>> 5, 64));
         $display("test random_input %0d ended", v);
      end
      finish_test();
   end
endmodule

// ===== dcac_top.sv
`timescale 1ns/100ps

// Function
// - Keep a high-time counter and a total-sample counter.
// - Sample comparator at one fixed period, identical for both branches.
// - Window equals total sample count times the sample period.
// - Clear both counters before each conversion.
// - Preload total counter so it overflows after 2048 samples.
// - Input above capacitor: drive high and count high time.
// - Total counter steps every sample; overflow ends conversion, result presented.
// - Counters are 12-bit binary counters.
// - Drive output polarity can be inverted.
// - Counter increments kept short; one cycle in each branch.
module dcac_top
(
   input  wire logic                       sys_clk,
   input  wire logic                       nrst,
   input  wire logic                       start,
   input  wire logic                       invert_drive,
   input  wire logic                       comparator_sense_input,
   output logic                            drive_out,
   output logic                            busy,
   output logic                            done,
   output logic [dcac_pkg::CNT_W-1:0]      result
);

   typedef enum logic [1:0] {ST_IDLE, ST_CLEAR, ST_RUN} dcac_state_e;

   // ****************************************************************
   // Reset release and input synchroniser.
   // ****************************************************************
   logic       rst_a_r;
   logic       rst_n;
   logic [2:0] cmp_sync_r;
   logic       cmp_state_r;
   logic       cmp_state_nxt;

   // Reset enters asynchronously and is released two edges later.
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_a_r <= 1'b0;
         rst_n   <= 1'b0;
      end
      else
      begin
         rst_a_r <= 1'b1;
         rst_n   <= rst_a_r;
      end
   end

   // The comparator level changes only once the last two stages agree.
   always_comb
   begin
      cmp_state_nxt = cmp_state_r;
      if (cmp_sync_r[1] == cmp_sync_r[2])
         cmp_state_nxt = cmp_sync_r[1];
   end

   // Three-stage sampling of the comparator pin.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cmp_sync_r  <= 3'h0;
         cmp_state_r <= 1'b0;
      end
      else
      begin
         cmp_sync_r  <= {cmp_sync_r[1:0], comparator_sense_input};
         cmp_state_r <= cmp_state_nxt;
      end
   end

   // ****************************************************************
   // Sequencer.
   // ****************************************************************
   dcac_cnt_if cif ();

   dcac_state_e                state_r;
   dcac_state_e                state_nxt;
   logic [3:0]                 div_r;
   logic [3:0]                 div_nxt;
   logic                       tick;
   logic                       level_r;
   logic                       level_nxt;
   logic                       done_r;
   logic                       done_nxt;
   logic [dcac_pkg::CNT_W-1:0] result_r;
   logic [dcac_pkg::CNT_W-1:0] result_nxt;

   // The sample enable fires every fixed period while running.
   assign tick = (state_r == ST_RUN) && (div_r == dcac_pkg::SAMPLE_PERIOD - 4'h1);

   // Next state; both comparator branches take the same single cycle.
   always_comb
   begin
      state_nxt  = state_r;
      div_nxt    = div_r;
      level_nxt  = level_r;
      done_nxt   = 1'b0;
      result_nxt = result_r;
      cif.clear  = 1'b0;
      cif.step   = 1'b0;
      cif.high   = 1'b0;
      case (state_r)
         ST_IDLE:
         begin
            if (start)
               state_nxt = ST_CLEAR;
         end
         ST_CLEAR:
         begin
            cif.clear = 1'b1;
            div_nxt   = dcac_pkg::DIV_RESET;
            state_nxt = ST_RUN;
         end
         ST_RUN:
         begin
            div_nxt = tick ? dcac_pkg::DIV_RESET : div_r + 4'h1;
            if (tick)
            begin
               cif.step  = 1'b1;
               cif.high  = cmp_state_r;
               level_nxt = cmp_state_r;
               if (cif.wrap)
               begin
                  state_nxt  = ST_IDLE;
                  done_nxt   = 1'b1;
                  result_nxt = cmp_state_r ? cif.high_cnt + 12'h001 : cif.high_cnt;
               end
            end
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer registers.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r  <= ST_IDLE;
         div_r    <= dcac_pkg::DIV_RESET;
         level_r  <= 1'b0;
         done_r   <= 1'b0;
         result_r <= dcac_pkg::CNT_RESET;
      end
      else
      begin
         state_r  <= state_nxt;
         div_r    <= div_nxt;
         level_r  <= level_nxt;
         done_r   <= done_nxt;
         result_r <= result_nxt;
      end
   end

   dcac_counters u_counters
   (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .cif     (cif)
   );

   // ****************************************************************
   // Outputs.
   // ****************************************************************
   // Drive level, optionally inverted for an inverting buffer.
   assign drive_out = level_r ^ invert_drive;
   assign busy      = (state_r != ST_IDLE);
   assign done      = done_r;
   assign result    = result_r;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   sequence s_sample_hi;
      tick && cmp_state_r;
   endsequence

   a_tick_spacing: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick |=> !tick [*3])
      else $error("Sample enable spacing broken.");

   a_drive_high: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_sample_hi |=> level_r)
      else $error("Drive not raised on high sample.");

   a_drive_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      tick && !cmp_state_r |=> !level_r)
      else $error("Drive not lowered on low sample.");

   a_polarity_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
      drive_out == (level_r ^ invert_drive))
      else $error("Drive polarity wrong.");

   a_clear_first: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_r == ST_CLEAR |=> cif.high_cnt == 12'h000)
      else $error("Counters not cleared.");

   a_done_end: assert property (@(posedge sys_clk) disable iff (!rst_n)
      done |-> !busy && $past(busy))
      else $error("Done without end of window.");

   a_window_len: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_r == ST_CLEAR |=> busy [*8])
      else $error("Window ended early.");

   a_result_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
      done |-> result <= 12'h800)
      else $error("Result exceeds sample count.");

   // ****************************************************************
   // Window length monitor.
   // ****************************************************************
   // Helper count of busy cycles, so the whole window can be checked at
   // its end without a long repetition that the tools would unroll.
   logic [13:0] win_cnt_r;
   logic [13:0] win_cnt_nxt;

   // Restart on the clear cycle, then count every busy cycle.
   always_comb
   begin
      win_cnt_nxt = win_cnt_r;
      if (state_r == ST_CLEAR)
         win_cnt_nxt = 14'h0001;
      else if (busy)
         win_cnt_nxt = win_cnt_r + 14'h0001;
   end

   // Monitor register.
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         win_cnt_r <= 14'h0000;
      else
         win_cnt_r <= win_cnt_nxt;
   end

   // ****************************************************************
   // Window and result checks.
   // ****************************************************************
   // A sample taken while the comparator reads low.
   sequence s_sample_lo;
      tick && !cmp_state_r;
   endsequence

   // The last sample of a window, the one that carries the total counter out.
   sequence s_last_sample;
      tick && cif.wrap;
   endsequence

   // One clear cycle plus every sample period of the window.
   a_window_total: assert property (@(posedge sys_clk) disable iff (!rst_n)
      done |-> win_cnt_r == 14'(dcac_pkg::TOTAL_SAMPLES) * 14'(dcac_pkg::SAMPLE_PERIOD)
               + 14'h0001)
      else $error("Window length differs from sample count times period.");

   a_window_exit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_last_sample |=> done && !busy)
      else $error("Window did not end on counter overflow.");

   a_run_holds: assert property (@(posedge sys_clk) disable iff (!rst_n)
      state_r == ST_RUN && !(tick && cif.wrap) |=> state_r == ST_RUN)
      else $error("Window left before overflow.");

   a_low_no_count: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_sample_lo |=> $stable(cif.high_cnt))
      else $error("High count moved on a low sample.");

   a_done_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      done |=> !done)
      else $error("Done held longer than one cycle.");

   a_result_held: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !done |-> $stable(result))
      else $error("Result changed outside end of window.");

   a_div_bound: assert property (@(posedge sys_clk) disable iff (!rst_n)
      div_r < dcac_pkg::SAMPLE_PERIOD)
      else $error("Sample divider out of range.");

   a_idle_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !busy |-> !tick && !cif.step)
      else $error("Sample taken outside a window.");

endmodule
